// ---- pkg/abe_pkg.sv ----
// Constants shared by the alarm block evaluator.
package abe_pkg;
  // Block table size and scan width.
  localparam int NUM_BLOCKS = 32;
  localparam int IDX_W = 5;
  localparam logic [4:0] LAST_IDX = 5'h1F;
  // Timing: the event timer runs in milliseconds on a 50 MHz clock.
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] DUR_RST = 16'h03E8;
  // APB byte offsets of the control group.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DURATION = 12'h004;
  localparam logic [11:0] OFS_ALARMS = 12'h008;
  localparam logic [11:0] OFS_IMBALANCE = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  // Per-block tables: base plus four times the block number.
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_CFG = 2'h1;
  localparam logic [1:0] REG_LEVEL = 2'h2;
  localparam logic [1:0] REG_DELAY = 2'h3;
  // Control register bit.
  localparam int CTRL_LATCH_RESET = 0;
  // Block configuration word fields.
  localparam int CFG_EN = 0;
  localparam int CFG_LATCH = 1;
  localparam int CFG_KIND = 2;
  localparam int CFG_MODE = 5;
  localparam int CFG_SRC = 8;
  localparam logic [11:0] CFG_MASK = 12'hF7F;
  // Block kinds.
  typedef enum logic [2:0] {
    KIND_LEVEL = 3'b000,
    KIND_SWITCH = 3'b001,
    KIND_TOGGLE = 3'b010,
    KIND_EXP_CONN = 3'b011,
    KIND_MEAS_CONN = 3'b100,
    KIND_CFG_FAULT = 3'b101,
    KIND_TIMED = 3'b110
  } abe_kind_t;
  // Comparison modes; switch blocks use bit 0 as active-when-open.
  typedef enum logic [1:0] {
    MODE_OVER = 2'b00,
    MODE_UNDER = 2'b01,
    MODE_IN_WIN = 2'b10,
    MODE_OUT_WIN = 2'b11
  } abe_mode_t;
  // Timed event alarm slots, selected by the source field.
  localparam int EVT_POWER_ON = 0;
  localparam int EVT_POWER_OFF = 1;
  localparam int EVT_DB_LOG = 2;
  localparam int EVT_FAST_LOG = 3;
  localparam int EVT_EVENT_LOG = 4;
  localparam int NUM_EVT = 5;
  // Fractional bits of the current imbalance ratio.
  localparam int IMB_FRAC = 8;
endpackage

// ---- rtl/abe_alarm_block_evaluator.sv ----
// Cyclic evaluator of thirty-two alarm blocks behind an APB register file.
//
// Summary of operation
// - Scan blocks one to thirty-two, repeating forever.
// - Latched holds until latch reset; others self-clear.
// - Latched states survive power cycling; only latch reset or disable clears. Here they survive powerDownEvt, but rst (power-up) clears alarmOut.
// - Latch reset keeps alarm while trip persists.
// - Latched hysteresis release uses trip-side setpoint.
// - Toggle input inverts alarm each activation; retained.
// - Switch block follows active physical input.
// - Over: trip above upper after delay, release below lower.
// - Under: trip below lower after delay, release above upper.
// - In-window trips after delay, releases outside band.
// - Out-window trips after delay, releases inside band.
// - Active-closed trips after delay, clears when open.
// - Active-open trips after delay, clears when closed.
// - Expansion connection fault alarms immediately while present.
// - Measurement connection fault alarms immediately while present.
// - Configuration fault alarms while configuration is inconsistent.
// - Power-on alarm lasts the activation duration.
// - Power-off alarm lasts the activation duration.
// - Each log reset alarms for activation duration.
// - One shared duration serves the four event-triggered timed alarms; power-on always loads DUR_RST at reset.
// - Imbalance is max minus average over larger base.
// - Latch reset releases all enabled latched blocks whose trip-side condition has cleared.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module abe_alarm_block_evaluator import abe_pkg::*; #(
  parameter int MS_DIV = MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measured values: four temperatures and three variables, 16 bits each.
  input wire logic [63:0] tempLevel,
  input wire logic [47:0] varLevel,
  // Phase currents and rated motor current.
  input wire logic [15:0] phaseCurrentA,
  input wire logic [15:0] phaseCurrentB,
  input wire logic [15:0] phaseCurrentC,
  input wire logic [15:0] ratedCurrent,
  // Physical digital inputs, high when the contact is closed.
  input wire logic [15:0] switchIn,
  // Supervision levels.
  input wire logic expConnFault,
  input wire logic measConnFault,
  input wire logic cfgFault,
  // One-cycle event pulses.
  input wire logic powerDownEvt,
  input wire logic dbLogResetEvt,
  input wire logic fastLogResetEvt,
  input wire logic eventLogResetEvt,
  // Alarm state of every block.
  output logic [31:0] alarmOut
);
  // Scan state and block tables.
  logic [IDX_W-1:0] scanIdx;
  logic [11:0] cfgMem [NUM_BLOCKS];
  logic [31:0] levelMem [NUM_BLOCKS];
  logic [15:0] delayMem [NUM_BLOCKS];
  logic [15:0] dlyCnt [NUM_BLOCKS];
  logic [31:0] prevIn;
  logic [31:0] pend;
  logic [15:0] duration;
  logic [15:0] imbalance;
  logic [15:0] evtTimer [NUM_EVT];
  logic [31:0] msCnt;
  logic msTick;

  // APB decode: a write takes effect on the edge where pready is seen high.
  wire logic access = psel && penable && !pready;
  wire logic [1:0] region = paddr[9:8];
  wire logic [IDX_W-1:0] wIdx = paddr[6:2];
  wire logic tableHit = (paddr[11:10] == 2'h0) && !paddr[7] && (paddr[1:0] == 2'h0);
  wire logic ctrlHit = (paddr == OFS_CTRL) || (paddr == OFS_DURATION)
    || (paddr == OFS_ALARMS) || (paddr == OFS_IMBALANCE) || (paddr == OFS_STATUS);
  wire logic mapped = ctrlHit || (tableHit && region != REG_CTRL);
  wire logic wrEdge = psel && penable && pready && pwrite && mapped;
  wire logic latchCmd = wrEdge && (paddr == OFS_CTRL) && pwdata[CTRL_LATCH_RESET];

  // Read mux; unmapped reads return zero with an error.
  logic [31:0] rdData;
  always_comb begin
    rdData = 32'h0000_0000;
    if (tableHit && region == REG_CFG) begin
      rdData = {20'h00000, cfgMem[wIdx]};
    end else if (tableHit && region == REG_LEVEL) begin
      rdData = levelMem[wIdx];
    end else if (tableHit && region == REG_DELAY) begin
      rdData = {16'h0000, delayMem[wIdx]};
    end else if (paddr == OFS_DURATION) begin
      rdData = {16'h0000, duration};
    end else if (paddr == OFS_ALARMS) begin
      rdData = alarmOut;
    end else if (paddr == OFS_IMBALANCE) begin
      rdData = {16'h0000, imbalance};
    end else if (paddr == OFS_STATUS) begin
      rdData = {27'h0000000, scanIdx};
    end
  end

  // Answer one cycle into the access phase, with data and error registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      prdata <= access ? rdData : 32'h0000_0000;
      pslverr <= access && !mapped;
    end
  end

  // Configuration tables and the shared activation duration.
  always_ff @(posedge clk) begin
    if (rst) begin
      duration <= DUR_RST;
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        cfgMem[i] <= 12'h000;
        levelMem[i] <= 32'h0000_0000;
        delayMem[i] <= 16'h0000;
      end
    end else if (wrEdge) begin
      if (paddr == OFS_DURATION) duration <= pwdata[15:0];
      if (tableHit && region == REG_CFG) cfgMem[wIdx] <= pwdata[11:0] & CFG_MASK;
      if (tableHit && region == REG_LEVEL) levelMem[wIdx] <= pwdata;
      if (tableHit && region == REG_DELAY) delayMem[wIdx] <= pwdata[15:0];
    end
  end

  // Current imbalance; the divisor is the larger of average and rated current.
  wire logic [15:0] maxAB = (phaseCurrentA > phaseCurrentB) ? phaseCurrentA : phaseCurrentB;
  wire logic [15:0] maxI = (maxAB > phaseCurrentC) ? maxAB : phaseCurrentC;
  wire logic [17:0] sumI = {2'b00, phaseCurrentA} + {2'b00, phaseCurrentB}
    + {2'b00, phaseCurrentC};
  wire logic [15:0] avgI = 16'(sumI / 18'd3);
  wire logic [15:0] diffI = (maxI > avgI) ? (maxI - avgI) : 16'h0000;
  wire logic [15:0] denI = (avgI > ratedCurrent) ? avgI : ratedCurrent;
  wire logic [23:0] numI = {diffI, 8'h00};
  wire logic [15:0] imbNext = (denI == 16'h0000) ? 16'h0000 : 16'(numI / {8'h00, denI});
  always_ff @(posedge clk) begin
    if (rst) imbalance <= 16'h0000;
    else imbalance <= imbNext;
  end

  // Millisecond prescaler for the timed event alarms.
  assign msTick = (msCnt == 32'(MS_DIV - 1));
  always_ff @(posedge clk) begin
    if (rst || msTick) msCnt <= 32'h0000_0000;
    else msCnt <= msCnt + 32'h0000_0001;
  end

  // Timed event countdowns; reset release counts as power-up.
  wire logic [NUM_EVT-1:0] evtPulse = {eventLogResetEvt, fastLogResetEvt,
    dbLogResetEvt, powerDownEvt, 1'b0};
  logic [7:0] evtOn;
  assign evtOn[7:NUM_EVT] = 3'b000;
  for (genvar e = 0; e < NUM_EVT; e++) begin : gEvt
    assign evtOn[e] = (evtTimer[e] != 16'h0000);
    // A new event reloads the full duration even mid-count.
    always_ff @(posedge clk) begin
      if (rst) evtTimer[e] <= (e == EVT_POWER_ON) ? DUR_RST : 16'h0000;
      else if (evtPulse[e]) evtTimer[e] <= duration;
      else if (msTick && evtOn[e]) evtTimer[e] <= evtTimer[e] - 16'h0001;
    end
  end

  // Fields of the block under evaluation.
  wire logic [11:0] cfg = cfgMem[scanIdx];
  wire logic blkEn = cfg[CFG_EN];
  wire logic blkLatch = cfg[CFG_LATCH];
  wire abe_kind_t kind = abe_kind_t'(cfg[CFG_KIND +: 3]);
  wire abe_mode_t mode = abe_mode_t'(cfg[CFG_MODE +: 2]);
  wire logic [3:0] src = cfg[CFG_SRC +: 4];
  wire logic [127:0] srcAll = {imbalance, varLevel, tempLevel};
  wire logic [15:0] val = srcAll[{src[2:0], 4'h0} +: 16];
  wire logic [15:0] upLvl = levelMem[scanIdx][31:16];
  wire logic [15:0] loLvl = levelMem[scanIdx][15:0];
  wire logic din = switchIn[src];
  wire logic curAlarm = alarmOut[scanIdx];
  wire logic curPend = pend[scanIdx];
  wire logic [15:0] curCnt = dlyCnt[scanIdx];
  wire logic above = val > upLvl;
  wire logic below = val < loLvl;

  // Trip, release and latched-hold conditions per kind and mode.
  logic trip;
  logic rel;
  logic hold;
  logic noDelay;
  always_comb begin
    trip = 1'b0;
    rel = 1'b1;
    hold = 1'b0;
    noDelay = 1'b0;
    case (kind)
      KIND_LEVEL: begin
        case (mode)
          MODE_OVER: begin
            trip = above;
            rel = below;
            hold = !(val < upLvl);
          end
          MODE_UNDER: begin
            trip = below;
            rel = above;
            hold = !(val > loLvl);
          end
          MODE_IN_WIN: begin
            trip = !above && !below;
            rel = !trip;
            hold = trip;
          end
          default: begin
            trip = above || below;
            rel = !trip;
            hold = trip;
          end
        endcase
      end
      KIND_SWITCH: begin
        trip = mode[0] ? !din : din;
        rel = !trip;
        hold = trip;
      end
      KIND_EXP_CONN: begin
        trip = expConnFault;
        noDelay = 1'b1;
        rel = !trip;
        hold = trip;
      end
      KIND_MEAS_CONN: begin
        trip = measConnFault;
        noDelay = 1'b1;
        rel = !trip;
        hold = trip;
      end
      KIND_CFG_FAULT: begin
        trip = cfgFault;
        noDelay = 1'b1;
        rel = !trip;
        hold = trip;
      end
      default: begin
        trip = 1'b0;
        rel = 1'b1;
        hold = 1'b0;
        noDelay = 1'b0;
      end
    endcase
  end

  // Next alarm and delay count of the visited block.
  logic next_alarm;
  logic [15:0] next_cnt;
  always_comb begin
    next_alarm = curAlarm;
    next_cnt = 16'h0000;
    if (!blkEn) begin
      next_alarm = 1'b0;
    end else if (kind == KIND_TOGGLE) begin
      if (din && !prevIn[scanIdx]) next_alarm = !curAlarm;
    end else if (kind == KIND_TIMED) begin
      next_alarm = evtOn[src[2:0]];
    end else if (curAlarm) begin
      if (blkLatch) next_alarm = !(curPend && !hold);
      else next_alarm = !rel;
    end else if (trip) begin
      // Delay counts in visits, so one unit is 32 clocks.
      if (noDelay || curCnt >= delayMem[scanIdx]) next_alarm = 1'b1;
      else next_cnt = curCnt + 16'h0001;
    end
  end

  // Scan pointer walks all blocks in ascending order.
  always_ff @(posedge clk) begin
    if (rst) scanIdx <= 5'h00;
    else scanIdx <= scanIdx + 5'h01;
  end

  // Per-block state. Power-down events never touch it (rst clears it), so latched and toggle
  // states persist across them; latch reset or disable clears a latched state, a press or disable a toggle.
  always_ff @(posedge clk) begin
    if (rst) begin
      alarmOut <= 32'h0000_0000;
      prevIn <= 32'h0000_0000;
      for (int i = 0; i < NUM_BLOCKS; i++) dlyCnt[i] <= 16'h0000;
    end else begin
      alarmOut[scanIdx] <= next_alarm;
      dlyCnt[scanIdx] <= next_cnt;
      prevIn[scanIdx] <= din;
    end
  end

  // Pending latch reset per block; a new command wins over the visit clear.
  wire logic [31:0] visitMask = 32'h0000_0001 << scanIdx;
  always_ff @(posedge clk) begin
    if (rst) pend <= 32'h0000_0000;
    else pend <= (pend & ~visitMask) | {32{latchCmd}};
  end

  // Checks, all on the single clock.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [IDX_W-1:0] lastIdx;
  always_ff @(posedge clk) lastIdx <= scanIdx;

  scan_order_a: assert property (scanIdx != LAST_IDX |=> scanIdx == $past(scanIdx) + 5'h01)
    else $error("Scan did not advance by one");
  scan_wrap_a: assert property (scanIdx == LAST_IDX |=> scanIdx == 5'h00)
    else $error("Scan did not wrap to first block");
  latch_hold_a: assert property (blkEn && blkLatch && curAlarm && !curPend && kind == KIND_LEVEL
    |=> alarmOut[lastIdx]) else $error("Latched alarm dropped without latch reset");
  latch_keep_a: assert property (blkEn && blkLatch && curAlarm && hold && kind != KIND_TOGGLE
    && kind != KIND_TIMED |=> alarmOut[lastIdx]) else $error("Latch reset cleared a tripped block");
  over_release_a: assert property (blkEn && !blkLatch && curAlarm && kind == KIND_LEVEL
    && mode == MODE_OVER && below |=> !alarmOut[lastIdx])
    else $error("Over-level alarm not released below lower level");
  toggle_flip_a: assert property (blkEn && kind == KIND_TOGGLE && din && !prevIn[scanIdx]
    |=> alarmOut[lastIdx] != $past(curAlarm)) else $error("Toggle did not invert alarm");
  conn_trip_a: assert property (blkEn && kind == KIND_EXP_CONN && expConnFault
    |=> alarmOut[lastIdx]) else $error("Expansion fault alarm not immediate");
  evt_load_a: assert property (dbLogResetEvt |=> evtTimer[EVT_DB_LOG] == $past(duration))
    else $error("Log reset timer not loaded with duration");
  delay_restart_a: assert property (blkEn && kind == KIND_LEVEL && !curAlarm && !trip
    |=> dlyCnt[lastIdx] == 16'h0000) else $error("Delay count not restarted");
  latch_cmd_a: assert property (latchCmd |=> pend == 32'hFFFF_FFFF)
    else $error("Latch reset not pending on all blocks");
endmodule

// ---- verif/abe_alarm_block_evaluator_tb.sv ----
// Self-checking bench for the alarm block evaluator.
`timescale 1ns/1ps
module abe_alarm_block_evaluator_tb import abe_pkg::*; ;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, s1;
  logic [63:0] tempLevel;
  logic [47:0] varLevel;
  logic [15:0] curA, curB, curC, rated, switchIn;
  logic [2:0] fault;
  logic [3:0] evt;
  logic [31:0] alarmOut;
  logic [2:0] expTab [4];
  int n_mismatch = 0;
  int n_checks = 0;
  // Small count per millisecond keeps the timed alarms short.
  abe_alarm_block_evaluator #(.MS_DIV(10)) abe_alarm_block_evaluator_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tempLevel(tempLevel), .varLevel(varLevel),
    .phaseCurrentA(curA), .phaseCurrentB(curB), .phaseCurrentC(curC),
    .ratedCurrent(rated), .switchIn(switchIn), .expConnFault(fault[0]),
    .measConnFault(fault[1]), .cfgFault(fault[2]), .powerDownEvt(evt[0]),
    .dbLogResetEvt(evt[1]), .fastLogResetEvt(evt[2]), .eventLogResetEvt(evt[3]),
    .alarmOut(alarmOut));
  abe_field_model abe_field_model_i (
    .clk(clk), .tempLevel(tempLevel), .varLevel(varLevel), .phaseCurrentA(curA),
    .phaseCurrentB(curB), .phaseCurrentC(curC), .ratedCurrent(rated),
    .switchIn(switchIn), .fault(fault), .evt(evt));
  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the answer is taken only at the edge that shows pready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Alarm bits are looked at mid-cycle, well clear of the updating edge.
  task automatic chkA(input int n, input logic e);
    @(negedge clk);
    chk({31'h0, alarmOut[n]}, {31'h0, e});
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(logic l, logic [2:0] k, logic [1:0] m, logic [3:0] s);
    return {20'h0, s, 1'b0, m, k, l, 1'b1};
  endfunction
  // Level blocks are always written with the upper one above the lower one.
  task automatic cfg(input int n, input logic [31:0] c, input logic [15:0] up, lo, dl);
    wr(12'h200 + 12'(n * 4), {up, lo});
    wr(12'h300 + 12'(n * 4), {16'h0, dl});
    wr(12'h100 + 12'(n * 4), c);
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // A hang ends the run as a failure.
  initial begin
    waitc(40000);
    n_mismatch++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    expTab = '{3'h4, 3'h3, 3'h2, 3'h5};
    waitc(12);
    rst <= 1'b0;
    @(posedge clk);
    cfg(0, cw(1'b0, KIND_TIMED, 2'h0, 4'(EVT_POWER_ON)), 16'h0, 16'h0, 16'h0);
    waitc(40);
    chkA(0, 1'b1);
    apb(1'b0, OFS_DURATION, 32'h0);
    chk(rd, {16'h0, DUR_RST});
    apb(1'b0, 12'hFFC, 32'h0);
    chk({rd[30:0], slv}, 32'h1);
    wr(12'h17C, 32'hFFFFFFFF);
    apb(1'b0, 12'h17C, 32'h0);
    chk(rd, {20'h0, CFG_MASK});
    apb(1'b0, OFS_STATUS, 32'h0);
    s1 = rd;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk((rd - s1) & 32'h1F, 32'h4);
    // Over level with a delay of three scans, then an interrupted trip.
    cfg(2, cw(1'b0, KIND_LEVEL, MODE_OVER, 4'h0), 16'h0064, 16'h0032, 16'h3);
    abe_field_model_i.setVal(0, 16'h0078);
    waitc(96);
    chkA(2, 1'b0);
    waitc(34);
    chkA(2, 1'b1);
    abe_field_model_i.setVal(0, 16'h0028);
    waitc(40);
    chkA(2, 1'b0);
    abe_field_model_i.setVal(0, 16'h0078);
    waitc(64);
    abe_field_model_i.setVal(0, 16'h0046);
    waitc(40);
    abe_field_model_i.setVal(0, 16'h0078);
    waitc(64);
    chkA(2, 1'b0);
    waitc(70);
    abe_field_model_i.setVal(0, 16'h0046);
    waitc(40);
    chkA(2, 1'b1);
    // All four comparison modes at values below, inside and above the band.
    cfg(5, cw(1'b0, KIND_LEVEL, MODE_OVER, 4'h4), 16'h00C8, 16'h0064, 16'h0);
    for (int m = 0; m < 4; m++) begin
      wr(12'h114, cw(1'b0, KIND_LEVEL, 2'(m), 4'h4));
      for (int i = 0; i < 3; i++) begin
        abe_field_model_i.setVal(4, 16'(50 + 100 * i));
        waitc(40);
        chkA(5, expTab[m][i]);
      end
    end
    // Contact blocks, closed-active then open-active, two scans of delay.
    cfg(6, cw(1'b0, KIND_SWITCH, 2'h0, 4'h3), 16'h0, 16'h0, 16'h2);
    abe_field_model_i.setSw(16'h0008);
    waitc(64);
    chkA(6, 1'b0);
    waitc(34);
    chkA(6, 1'b1);
    abe_field_model_i.setSw(16'h0000);
    waitc(40);
    chkA(6, 1'b0);
    wr(12'h118, cw(1'b0, KIND_SWITCH, 2'h1, 4'h3));
    waitc(100);
    chkA(6, 1'b1);
    abe_field_model_i.setSw(16'h0008);
    waitc(40);
    chkA(6, 1'b0);
    // Toggle input flips on each press and survives a power-down.
    cfg(7, cw(1'b0, KIND_TOGGLE, 2'h0, 4'h5), 16'h0, 16'h0, 16'h0);
    for (int i = 0; i < 2; i++) begin
      abe_field_model_i.setSw(16'h0020);
      waitc(40);
      abe_field_model_i.setSw(16'h0000);
      waitc(40);
      chkA(7, 1'(i == 0));
    end
    abe_field_model_i.setSw(16'h0020);
    waitc(40);
    abe_field_model_i.pulse(0);
    waitc(40);
    chkA(7, 1'b1);
    // Supervision kinds ignore their delay setting.
    for (int i = 0; i < 3; i++) begin
      cfg(8 + i, cw(1'b0, 3'(3 + i), 2'h0, 4'h0), 16'h0, 16'h0, 16'h5);
      abe_field_model_i.setFlt(3'(1 << i));
      waitc(33);
      chkA(8 + i, 1'b1);
      abe_field_model_i.setFlt(3'h0);
      waitc(33);
      chkA(8 + i, 1'b0);
    end
    // Latched over-level block through release, power-down and latch reset.
    cfg(11, cw(1'b1, KIND_LEVEL, MODE_OVER, 4'h1), 16'h0064, 16'h0032, 16'h4);
    abe_field_model_i.setVal(1, 16'h0078);
    waitc(170);
    abe_field_model_i.setVal(1, 16'h0028);
    waitc(40);
    chkA(11, 1'b1);
    abe_field_model_i.pulse(0);
    waitc(40);
    chkA(11, 1'b1);
    abe_field_model_i.setVal(1, 16'h0078);
    wr(OFS_CTRL, 32'h1);
    waitc(40);
    chkA(11, 1'b1);
    abe_field_model_i.setVal(1, 16'h0046);
    waitc(40);
    chkA(11, 1'b1);
    wr(OFS_CTRL, 32'h1);
    waitc(40);
    chkA(11, 1'b0);
    // Timed alarms share one ten-millisecond duration.
    wr(OFS_DURATION, 32'hA);
    for (int e = 1; e < 5; e++) begin
      cfg(12 + e, cw(1'b0, KIND_TIMED, 2'h0, 4'(e)), 16'h0, 16'h0, 16'h0);
      abe_field_model_i.pulse(e - 1);
      waitc(40);
      chkA(12 + e, 1'b1);
      waitc(110);
      chkA(12 + e, 1'b0);
    end
    abe_field_model_i.pulse(1);
    waitc(80);
    abe_field_model_i.pulse(1);
    waitc(80);
    chkA(14, 1'b1);
    // Imbalance with the average above, then below, the rated current.
    abe_field_model_i.setCur(16'h0078, 16'h0078, 16'h0090, 16'h0032);
    waitc(5);
    apb(1'b0, OFS_IMBALANCE, 32'h0);
    chk(rd, 32'h20);
    abe_field_model_i.setCur(16'h0078, 16'h0078, 16'h0090, 16'h0100);
    waitc(5);
    apb(1'b0, OFS_IMBALANCE, 32'h0);
    chk(rd, 32'h10);
    waitc(10100);
    chkA(0, 1'b0);
    end_of_test();
  end
endmodule

// ---- verif/abe_field_model.sv ----
// Field-side model: measured values, contacts, supervision faults and events.
`timescale 1ns/1ps
module abe_field_model (
  // Clock.
  input wire logic clk,
  // Measured values.
  output logic [63:0] tempLevel,
  output logic [47:0] varLevel,
  output logic [15:0] phaseCurrentA,
  output logic [15:0] phaseCurrentB,
  output logic [15:0] phaseCurrentC,
  output logic [15:0] ratedCurrent,
  // Contacts and supervision levels.
  output logic [15:0] switchIn,
  output logic [2:0] fault,
  // Power-down and the three log resets, one-cycle pulses.
  output logic [3:0] evt
);
  // Requested field state; the pins follow it at the next rising edge.
  logic [63:0] tNext;
  logic [47:0] vNext;
  logic [63:0] cNext;
  logic [15:0] sNext;
  logic [2:0] fNext;
  logic [3:0] eNext;
  // Everything starts quiet; modules connected, contacts open.
  initial begin
    tNext = 64'h0;
    vNext = 48'h0;
    cNext = 64'h0;
    sNext = 16'h0;
    fNext = 3'h0;
    eNext = 4'h0;
  end
  // Pins are registered, so the block never sees a change mid-cycle.
  always_ff @(posedge clk) begin
    tempLevel <= tNext;
    varLevel <= vNext;
    {phaseCurrentA, phaseCurrentB, phaseCurrentC, ratedCurrent} <= cNext;
    switchIn <= sNext;
    fault <= fNext;
    evt <= eNext;
  end
  // Callers sit just after a rising edge, so a request reaches the pins one edge later.
  task automatic setVal(input int idx, input logic [15:0] v);
    if (idx < 4) tNext[idx*16 +: 16] <= v;
    else vNext[(idx-4)*16 +: 16] <= v;
  endtask
  task automatic setCur(input logic [15:0] a, b, c, r);
    cNext <= {a, b, c, r};
  endtask
  task automatic setSw(input logic [15:0] v);
    sNext <= v;
  endtask
  task automatic setFlt(input logic [2:0] f);
    fNext <= f;
  endtask
  // A pulse must not last longer than one cycle or it would reload the timer more than once.
  task automatic pulse(input int e);
    eNext[e] <= 1'b1;
    @(posedge clk);
    eNext[e] <= 1'b0;
  endtask
endmodule
